// ===== hw/lsd_pkg.sv
// Shared constants and state encodings for the linear sensor drive timing pair
package lsd_pkg;

  // ---------------------------------------------------------------
  // Array geometry
  // ---------------------------------------------------------------
  localparam int PIX_W = 8;
  localparam int CNT_W = 9;
  localparam int VID_W = 16;
  localparam logic [CNT_W-1:0] PIXELS = 9'h100;

  // ---------------------------------------------------------------
  // Scan shape per variant, in sensor clock periods
  // ---------------------------------------------------------------
  localparam logic [3:0] SLOW_OVH     = 4'hA;
  localparam logic [3:0] SLOW_PER_PIX = 4'h8;
  localparam logic [3:0] FAST_OVH     = 4'h6;
  localparam logic [3:0] FAST_PER_PIX = 4'h1;
  localparam logic [3:0] PHASE_FIRST  = 4'h1;

  // Falls to wait after a reset edge: coincident with a fall, or not
  localparam logic [1:0] ALIGN_SYNC  = 2'h1;
  localparam logic [1:0] ALIGN_ASYNC = 2'h2;
  localparam logic [1:0] ALIGN_FIRE  = 2'h1;

  // Full scan lengths and slack for reset alignment
  localparam logic [15:0] SCAN_SLOW   = 16'h080A;
  localparam logic [15:0] SCAN_FAST   = 16'h0106;
  localparam logic [15:0] SCAN_MARGIN = 16'h0004;

  // ---------------------------------------------------------------
  // Timing at clk_sys
  // ---------------------------------------------------------------
  localparam int CLK_SYS_NS = 40;
  localparam int RST_MIN_NS = 6000;
  localparam int GAP_MIN_NS = 3000;
  localparam logic [7:0] RST_MIN_CYC = 8'((RST_MIN_NS + CLK_SYS_NS - 1) / CLK_SYS_NS);
  localparam logic [7:0] GAP_MIN_CYC = 8'((GAP_MIN_NS + CLK_SYS_NS - 1) / CLK_SYS_NS);
  // Sensor clock half period in clk_sys cycles: 25 MHz / 20 = 1.25 MHz
  localparam logic [3:0] SCLK_HALF   = 4'hA;

  // ---------------------------------------------------------------
  // State encodings
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    LSD_S_IDLE = 3'h1,
    LSD_S_OVH  = 3'h2,
    LSD_S_PIX  = 3'h4
  } lsd_scan_e;

  typedef enum logic [3:0] {
    LSD_H_IDLE = 4'h1,
    LSD_H_HIGH = 4'h2,
    LSD_H_LOW  = 4'h4,
    LSD_H_GAP  = 4'h8
  } lsd_host_e;

endpackage

// ===== hw/lsd_if.sv
// Link between the timing generator and the sensor readout end
`timescale 1ns/10ps
interface lsd_if;
  logic                      sclk;
  logic                      srst;
  logic                      trig;
  logic [lsd_pkg::VID_W-1:0] vid;

  modport sensor (input sclk, input srst, output trig, output vid);
  modport timing (output sclk, output srst, input trig, input vid);
endinterface

// ===== hw/lsd_sensor.sv
// Sensor end: integration window and serial pixel readout driven by the link
`timescale 1ns/10ps
module lsd_sensor (
  // System
  input  wire logic                      clk_sys,
  input  wire logic                      sys_rst,
  // Link
  lsd_if.sensor                          lk,
  // User side
  input  wire logic                      fast_mode,
  input  wire logic [lsd_pkg::VID_W-1:0] pixel_level,
  output logic      [lsd_pkg::PIX_W-1:0] pixel_index,
  output logic                           integrating,
  output logic                           scan_busy,
  output logic                           scan_done
);

  // ---------------------------------------------------------------
  // Link edge detection
  // ---------------------------------------------------------------
  logic                      sclk_q;
  logic                      srst_q;
  logic                      sclk_fall;
  logic                      srst_rise;
  logic                      srst_fall;
  logic [1:0]                start_cnt;
  logic [1:0]                end_cnt;
  logic                      integ_go;
  logic                      scan_go;
  logic [3:0]                ovh_len;
  logic [3:0]                per_pix;
  logic [3:0]                phase;
  logic [lsd_pkg::CNT_W-1:0] pix_cnt;
  logic                      emit;
  logic                      finish;
  logic                      trig;
  logic [lsd_pkg::VID_W-1:0] vid;
  lsd_pkg::lsd_scan_e        state;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sclk_q <= 1'b0;
      srst_q <= 1'b0;
    end else begin
      sclk_q <= lk.sclk;
      srst_q <= lk.srst;
    end
  end

  assign sclk_fall = sclk_q & ~lk.sclk;
  assign srst_rise = ~srst_q & lk.srst;
  assign srst_fall = srst_q & ~lk.srst;

  // Edges are seen at clk_sys resolution only: a reset edge and a clock fall
  // count as coincident when both show in the same cycle

  // ---------------------------------------------------------------
  // Integration start and end alignment
  // ---------------------------------------------------------------
  // A fall in the same cycle as the reset edge arms the shorter wait
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      start_cnt <= 2'h0;
    end else if (srst_rise) begin
      start_cnt <= sclk_fall ? lsd_pkg::ALIGN_SYNC : lsd_pkg::ALIGN_ASYNC;
    end else if (sclk_fall && start_cnt != 2'h0) begin
      start_cnt <= start_cnt - 2'h1;
    end
  end

  // Both counters rest at zero once their wait has fired
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      end_cnt <= 2'h0;
    end else if (srst_fall) begin
      end_cnt <= sclk_fall ? lsd_pkg::ALIGN_SYNC : lsd_pkg::ALIGN_ASYNC;
    end else if (sclk_fall && end_cnt != 2'h0) begin
      end_cnt <= end_cnt - 2'h1;
    end
  end

  assign integ_go = sclk_fall && !srst_rise && start_cnt == lsd_pkg::ALIGN_FIRE;
  assign scan_go  = sclk_fall && !srst_fall && end_cnt == lsd_pkg::ALIGN_FIRE;

  // Integration window follows the reset pulse, so its span is set by the pulse timing
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      integrating <= 1'b0;
    end else if (integ_go) begin
      integrating <= 1'b1;
    end else if (scan_go) begin
      integrating <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Scan sequencer
  // ---------------------------------------------------------------
  // Slot lengths follow fast_mode directly; changing it during a scan
  // bends the slot in progress, so the user must hold it between lines
  always_comb begin
    ovh_len = fast_mode ? lsd_pkg::FAST_OVH : lsd_pkg::SLOW_OVH;
    per_pix = fast_mode ? lsd_pkg::FAST_PER_PIX : lsd_pkg::SLOW_PER_PIX;
  end

  assign emit = sclk_fall && (
                  (state == lsd_pkg::LSD_S_OVH && phase == ovh_len) ||
                  (state == lsd_pkg::LSD_S_PIX && phase == per_pix &&
                   pix_cnt != lsd_pkg::PIXELS));
  assign finish = sclk_fall && state == lsd_pkg::LSD_S_PIX && phase == per_pix &&
                  pix_cnt == lsd_pkg::PIXELS;

  // A new integration end restarts the scan; an unfinished one is lost
  // Scan starts only after the aligned end of integration, hence a little late
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state <= lsd_pkg::LSD_S_IDLE;
    end else if (scan_go) begin
      state <= lsd_pkg::LSD_S_OVH;
    end else begin
      unique case (state)
        lsd_pkg::LSD_S_IDLE: begin
          state <= lsd_pkg::LSD_S_IDLE;
        end
        lsd_pkg::LSD_S_OVH: begin
          if (emit) begin
            state <= lsd_pkg::LSD_S_PIX;
          end
        end
        lsd_pkg::LSD_S_PIX: begin
          if (finish) begin
            state <= lsd_pkg::LSD_S_IDLE;
          end
        end
      endcase
    end
  end

  // Periods elapsed within the current overhead or pixel slot
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      phase <= lsd_pkg::PHASE_FIRST;
    end else if (scan_go || emit) begin
      phase <= lsd_pkg::PHASE_FIRST;
    end else if (sclk_fall && state != lsd_pkg::LSD_S_IDLE) begin
      phase <= phase + 4'h1;
    end
  end

  // Pixels emitted so far; one bit wider than the index so a full line shows
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pix_cnt <= '0;
    end else if (scan_go) begin
      pix_cnt <= '0;
    end else if (emit) begin
      pix_cnt <= pix_cnt + 9'h001;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Video is held between strobes so the capture side may read it late
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      trig <= 1'b0;
      vid  <= '0;
    end else begin
      trig <= emit;
      if (emit) begin
        vid <= pixel_level;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      scan_done   <= 1'b0;
      scan_busy   <= 1'b0;
      pixel_index <= '0;
    end else begin
      scan_done   <= finish;
      scan_busy   <= scan_go || (state != lsd_pkg::LSD_S_IDLE && !finish);
      // Index leads the strobe so the user level is ready in the emit cycle
      if (scan_go) begin
        pixel_index <= '0;
      end else if (emit) begin
        pixel_index <= pix_cnt[lsd_pkg::PIX_W-1:0] + 8'h01;
      end else begin
        pixel_index <= pix_cnt[lsd_pkg::PIX_W-1:0];
      end
    end
  end

  assign lk.trig = trig;
  assign lk.vid  = vid;

endmodule // lsd_sensor

// ===== hw/lsd_timing_gen.sv
// Timing generator end: makes the sensor clock and reset pulses, collects pixels
`timescale 1ns/10ps
module lsd_timing_gen (
  // System
  input  wire logic                      clk_sys,
  input  wire logic                      sys_rst,
  // Link
  lsd_if.timing                          lk,
  // User side
  input  wire logic                      run,
  input  wire logic                      fast_mode,
  input  wire logic [15:0]               integ_periods,
  output logic                           pixel_valid,
  output logic      [lsd_pkg::VID_W-1:0] pixel_data,
  output logic      [lsd_pkg::PIX_W-1:0] pixel_num,
  output logic                           line_done
);

  // ---------------------------------------------------------------
  // Sensor clock divider
  // ---------------------------------------------------------------
  logic [3:0]         div_cnt;
  logic               sclk;
  logic               srst;
  logic               tick;
  logic               sclk_rise;
  logic               sclk_fall;
  logic [7:0]         cyc_cnt;
  logic [15:0]        per_cnt;
  logic [15:0]        scan_len;
  lsd_pkg::lsd_host_e state;

  assign tick      = div_cnt == lsd_pkg::SCLK_HALF - 4'h1;
  assign sclk_rise = tick && !sclk;
  assign sclk_fall = tick && sclk;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      div_cnt <= 4'h0;
      sclk    <= 1'b0;
    end else if (tick) begin
      div_cnt <= 4'h0;
      sclk    <= ~sclk;
    end else begin
      div_cnt <= div_cnt + 4'h1;
    end
  end

  // Scan length plus slack, since alignment can add clock periods
  assign scan_len = (fast_mode ? lsd_pkg::SCAN_FAST : lsd_pkg::SCAN_SLOW) +
                    lsd_pkg::SCAN_MARGIN;

  // ---------------------------------------------------------------
  // Reset pulse scheduler
  // ---------------------------------------------------------------
  // Reset edges move on sensor clock rises so they never meet a fall
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state <= lsd_pkg::LSD_H_IDLE;
      srst  <= 1'b0;
    end else begin
      unique case (state)
        lsd_pkg::LSD_H_IDLE: begin
          if (run && sclk_rise) begin
            state <= lsd_pkg::LSD_H_HIGH;
            srst  <= 1'b1;
          end
        end
        lsd_pkg::LSD_H_HIGH: begin
          if (sclk_rise && cyc_cnt >= lsd_pkg::RST_MIN_CYC &&
              per_cnt >= integ_periods) begin
            state <= lsd_pkg::LSD_H_LOW;
            srst  <= 1'b0;
          end
        end
        lsd_pkg::LSD_H_LOW: begin
          if (per_cnt >= scan_len) begin
            state <= lsd_pkg::LSD_H_GAP;
          end
        end
        lsd_pkg::LSD_H_GAP: begin
          if (cyc_cnt >= lsd_pkg::GAP_MIN_CYC && sclk_rise) begin
            state <= run ? lsd_pkg::LSD_H_HIGH : lsd_pkg::LSD_H_IDLE;
            srst  <= run;
          end
        end
      endcase
    end
  end

  // Cycle counter saturates; restarts as each pulse and each gap begins, so a pulse
  // that follows a gap directly is still timed from its own rising edge
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cyc_cnt <= 8'h00;
    end else if (state == lsd_pkg::LSD_H_IDLE ||
                 (state == lsd_pkg::LSD_H_LOW && per_cnt >= scan_len) ||
                 (state == lsd_pkg::LSD_H_GAP && sclk_rise &&
                  cyc_cnt >= lsd_pkg::GAP_MIN_CYC)) begin
      cyc_cnt <= 8'h00;
    end else if (cyc_cnt != 8'hFF) begin
      cyc_cnt <= cyc_cnt + 8'h01;
    end
  end

  // Sensor clock periods since the last reset edge
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      per_cnt <= 16'h0000;
    end else if (state == lsd_pkg::LSD_H_IDLE || state == lsd_pkg::LSD_H_GAP ||
                 (state == lsd_pkg::LSD_H_HIGH && sclk_rise && cyc_cnt >= lsd_pkg::RST_MIN_CYC &&
                  per_cnt >= integ_periods)) begin
      per_cnt <= 16'h0000;
    end else if (sclk_fall && per_cnt != 16'hFFFF) begin
      per_cnt <= per_cnt + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // Pixel capture
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pixel_valid <= 1'b0;
      pixel_data  <= '0;
      pixel_num   <= '0;
      line_done   <= 1'b0;
    end else begin
      pixel_valid <= lk.trig;
      line_done   <= state == lsd_pkg::LSD_H_LOW && per_cnt >= scan_len;
      if (lk.trig) begin
        pixel_data <= lk.vid;
      end
      if (state == lsd_pkg::LSD_H_HIGH) begin
        pixel_num <= '0;
      end else if (pixel_valid) begin
        pixel_num <= pixel_num + 8'h01;
      end
    end
  end

  assign lk.sclk = sclk;
  assign lk.srst = srst;

endmodule // lsd_timing_gen

// ===== tb/lsd_link_chk.sv
// Concurrent checks on the link between timing generator and sensor
`timescale 1ns/10ps
module lsd_link_chk (
  // System
  input wire logic                      clk_sys,
  input wire logic                      sys_rst,
  // Link
  input wire logic                      sclk,
  input wire logic                      srst,
  input wire logic                      trig,
  input wire logic [lsd_pkg::VID_W-1:0] vid
);
  // ------------------------------------------
  // Helper counters
  // ------------------------------------------
  // Idle counters start saturated so the first pulse after reset is not judged too soon
  logic [15:0] hi_cnt;
  logic [15:0] lo_cnt;
  logic [15:0] tr_cnt;
  logic [8:0]  px_cnt;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      hi_cnt <= 16'h0000;
      lo_cnt <= 16'hFFFF;
      tr_cnt <= 16'hFFFF;
      px_cnt <= 9'h000;
    end else begin
      hi_cnt <= srst ? hi_cnt + 16'h0001 : 16'h0000;
      lo_cnt <= srst ? 16'h0000 : (lo_cnt == 16'hFFFF ? lo_cnt : lo_cnt + 16'h0001);
      tr_cnt <= trig ? 16'h0000 : (tr_cnt == 16'hFFFF ? tr_cnt : tr_cnt + 16'h0001);
      px_cnt <= srst ? 9'h000 : (trig ? px_cnt + 9'h001 : px_cnt);
    end
  end

  // ------------------------------------------
  // Assertions
  // ------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  rst_width_a: assert property ($fell(srst) |-> hi_cnt >= 16'h0096)
    else $error("reset pulse shorter than six microseconds");
  low_span_a: assert property ($rose(srst) |-> lo_cnt >= 16'h1478)
    else $error("reset low period shorter than a scan");
  gap_span_a: assert property ($rose(srst) |-> tr_cnt >= 16'h004B)
    else $error("reset rose too soon after last pixel");
  pix_space_a: assert property (trig |-> tr_cnt == 16'h0013 ||
                                tr_cnt == 16'h009F || tr_cnt > 16'h00C8)
    else $error("pixel spacing is neither one nor eight clocks");
  pix_count_a: assert property ($rose(srst) |-> px_cnt == 9'h000 || px_cnt == 9'h100)
    else $error("scan did not hold all pixels");
  sclk_rate_a: assert property ($changed(sclk) |=> $stable(sclk)[*8] ##1
                                $stable(sclk) ##1 $changed(sclk))
    else $error("sensor clock half period wrong");
  trig_low_a: assert property (trig |-> !srst)
    else $error("pixel emitted while reset high");
  vid_hold_a: assert property ($changed(vid) |-> trig)
    else $error("video changed without a strobe");

  cover property ($rose(srst));
  cover property (trig && tr_cnt == 16'h0013);
  cover property (trig && tr_cnt == 16'h009F);
endmodule // lsd_link_chk

// ===== tb/linear_sensor_drive_timing_bench.sv
// Self-checking bench joining the timing generator and the sensor end
`timescale 1ns/10ps
module linear_sensor_drive_timing_bench;
  logic                      clk_sys       = 1'b0;
  logic                      sys_rst       = 1'b1;
  logic                      run           = 1'b0;
  logic                      fast_mode     = 1'b1;
  logic [15:0]               integ_periods = 16'h0001;
  logic [15:0]               pixel_level   = 16'h0000;
  logic [lsd_pkg::PIX_W-1:0] pixel_index;
  logic [lsd_pkg::PIX_W-1:0] pixel_num;
  logic [15:0]               pixel_data;
  logic                      integrating;
  logic                      scan_busy;
  logic                      scan_done;
  logic                      pixel_valid;
  logic                      line_done;
  int                        fails = 0;
  int                        checked = 0;

  lsd_if lk ();
  always #20 clk_sys = ~clk_sys;
  // Level tagged with its index so a skipped or repeated pixel shows up
  always @(posedge clk_sys) pixel_level <= #1 {8'hA5, pixel_index};

  lsd_sensor lsd_sensor_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .lk(lk),
    .fast_mode(fast_mode), .pixel_level(pixel_level), .pixel_index(pixel_index),
    .integrating(integrating), .scan_busy(scan_busy), .scan_done(scan_done));
  lsd_timing_gen lsd_timing_gen_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .lk(lk),
    .run(run), .fast_mode(fast_mode), .integ_periods(integ_periods),
    .pixel_valid(pixel_valid), .pixel_data(pixel_data), .pixel_num(pixel_num),
    .line_done(line_done));
  lsd_link_chk lsd_link_chk_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .sclk(lk.sclk),
    .srst(lk.srst), .trig(lk.trig), .vid(lk.vid));

  // ------------------------------------------
  // Shared tasks
  // ------------------------------------------
  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask

  task automatic chk_v(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_n(input int got, input int exp, input string what);
    checked++;
    if (got != exp) begin
      fails++;
      $display("mismatch at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ------------------------------------------
  // Scenarios
  // ------------------------------------------
  // Positions are counted in sensor clock falls, so sync latency inside the ends cancels
  // The scan starts on the second fall after the reset fall, as the host never aligns them
  task automatic run_line(input logic fm, input logic [15:0] ip, input int ovh, input int per);
    int   f, fr, fi, ff, fj, k, n;
    logic ps, pr, pi;
    f = 0; fr = 0; fi = 0; ff = 0; fj = 0; k = 0;
    ps = lk.sclk; pr = lk.srst; pi = integrating;
    fast_mode = fm;
    integ_periods = ip;
    run = 1'b1;
    for (n = 0; n < 50000 && scan_done !== 1'b1; n++) begin
      tick;
      if (ps === 1'b1 && lk.sclk === 1'b0) f++;
      if (pr !== 1'b1 && lk.srst === 1'b1) fr = f;
      if (pr === 1'b1 && lk.srst === 1'b0) ff = f;
      if (pi !== 1'b1 && integrating === 1'b1) fi = f;
      if (pi === 1'b1 && integrating === 1'b0) fj = f;
      if (lk.trig === 1'b1) begin
        chk_n(f - ff, 2 + ovh + k * per, "pixel position");
        k++;
      end
      if (pixel_valid === 1'b1) chk_v(pixel_data, {8'hA5, pixel_num}, "pixel value");
      ps = lk.sclk; pr = lk.srst; pi = integrating;
    end
    if (scan_done !== 1'b1) begin
      fails++;
      conclude;
    end
    chk_n(k, 256, "pixel count");
    chk_n(f - ff, 2 + ovh + 256 * per, "scan length");
    chk_n(fi - fr, 2, "integration start");
    chk_n(fj - fi, ff - fr, "integration span");
    chk_n(int'(ff - fr >= int'(ip)), 1, "reset width");
    run = 1'b0;
    for (n = 0; n < 400 && line_done !== 1'b1; n++) tick;
    chk_v({15'h0000, line_done}, 16'h0001, "line end");
    repeat (120) tick;
    chk_v({15'h0000, lk.srst}, 16'h0000, "idle after stop");
    $display("line finished fast=%0b pixels=%0d", fm, k);
  endtask

  // Run held across two lines, so the second pulse follows the gap directly
  task automatic back_to_back;
    int n, hi, lines;
    hi = 0;
    lines = 0;
    fast_mode = 1'b1;
    integ_periods = 16'h0001;
    run = 1'b1;
    for (n = 0; n < 20000 && lines < 2; n++) begin
      tick;
      if (lk.srst === 1'b1) hi++;
      if (scan_done === 1'b1) begin
        lines++;
        chk_n(int'(hi >= int'(lsd_pkg::RST_MIN_CYC)), 1, "pulse width");
        hi = 0;
      end
    end
    run = 1'b0;
    if (lines < 2) begin
      fails++;
      conclude;
    end
    for (n = 0; n < 400 && line_done !== 1'b1; n++) tick;
    chk_v({15'h0000, line_done}, 16'h0001, "pair end");
    repeat (120) tick;
    chk_v({15'h0000, lk.srst}, 16'h0000, "idle after pair");
    $display("back-to-back lines finished");
  endtask

  // A reset in mid-scan must clear both ends at once
  task automatic mid_reset;
    fast_mode = 1'b1;
    integ_periods = 16'h0001;
    run = 1'b1;
    repeat (1500) tick;
    chk_v({15'h0000, scan_busy}, 16'h0001, "scan running");
    sys_rst = 1'b1;
    run = 1'b0;
    repeat (2) tick;
    sys_rst = 1'b0;
    tick;
    chk_v({15'h0000, lk.srst}, 16'h0000, "reset cleared");
    chk_v({15'h0000, scan_busy}, 16'h0000, "scan cut");
    chk_v({8'h00, pixel_index}, 16'h0000, "index cleared");
    $display("mid-scan reset finished");
  endtask

  initial begin
    repeat (12) tick;
    sys_rst = 1'b0;
    run_line(1'b1, 16'h0001, 6, 1);
    run_line(1'b0, 16'h0001, 10, 8);
    run_line(1'b1, 16'h0028, 6, 1);
    back_to_back;
    mid_reset;
    run_line(1'b1, 16'h0002, 6, 1);
    conclude;
  end
endmodule // linear_sensor_drive_timing_bench
